// >>> hdl/ef_stage_block.sv
// Four-stage directional earth fault sequencing, events and records
`timescale 1ns/1ns
`default_nettype none

module ef_stage_block
  import ef_stage_pkg::*;
#(
  parameter int NS          = NUM_STAGES,
  parameter int TICK_CYCLES = ef_stage_pkg::TICK_CYCLES
) (
  input  wire logic                I_CLK,
  input  wire logic                I_SYS_RST,
  input  wire logic                I_CE,
  input  wire logic [NS-1:0]       I_PICKUP,
  input  wire logic [NS-1:0]       I_RES_PICKUP,
  input  wire logic [NS-1:0]       I_CAP_PICKUP,
  input  wire logic [NS-1:0]       I_BLOCK,
  input  wire logic [NS*DLY_W-1:0] I_INV_DELAY,
  input  wire logic [RATIO_W-1:0]  I_HARM_RATIO,
  input  wire logic [MEAS_W-1:0]   I_RES_CURRENT,
  input  wire logic [MEAS_W-1:0]   I_RES_PART,
  input  wire logic [MEAS_W-1:0]   I_CAP_PART,
  input  wire logic [MEAS_W-1:0]   I_RESID_V_PCT,
  input  wire logic [MEAS_W-1:0]   I_RESID_V_VOLT,
  input  wire logic [MEAS_W-1:0]   I_ANGLE,
  input  wire logic [GRP_W-1:0]    I_SET_GROUP,
  input  wire logic [GND_W-1:0]    I_NET_GND,
  input  wire logic [TIME_W-1:0]   I_TIME_MS,
  input  wire logic                  I_CFG_LOAD,
  input  wire logic [NS-1:0]         I_CFG_INRUSH_EN,
  input  wire logic [NS*RATIO_W-1:0] I_CFG_RATIO_LIMIT,
  input  wire logic [NS-1:0]         I_CFG_BROAD,
  input  wire logic [NS-1:0]         I_CFG_SEPARATE,
  input  wire logic [NS-1:0]         I_CFG_INVERSE,
  input  wire logic [NS*DLY_W-1:0]   I_CFG_DLY_COMMON,
  input  wire logic [NS*DLY_W-1:0]   I_CFG_DLY_COMP,
  input  wire logic [NS*DLY_W-1:0]   I_CFG_DLY_UNEARTH,
  input  wire logic [NS*DLY_W-1:0]   I_CFG_DLY_RELEASE,
  input  wire logic [NUM_ST-1:0]     I_CFG_EVT_ON,
  input  wire logic [NUM_ST-1:0]     I_CFG_EVT_OFF,
  input  wire logic [STAGE_W-1:0]  I_REC_STAGE,
  input  wire logic [REC_AW-1:0]   I_REC_AGE,
  output logic      [NS-1:0]       O_START,
  output logic      [NS-1:0]       O_TRIP,
  output logic      [NS-1:0]       O_BLOCKED,
  output logic      [NS-1:0]       O_RES_START,
  output logic      [NS-1:0]       O_CAP_START,
  output logic      [NS-1:0]       O_RES_TRIP,
  output logic      [NS-1:0]       O_CAP_TRIP,
  output logic      [NS*DLY_W-1:0] O_REMAIN,
  output logic                     O_EVT_VALID,
  output logic      [STAGE_W-1:0]  O_EVT_STAGE,
  output logic      [EVT_W-1:0]    O_EVT_CODE,
  output logic      [TIME_W-1:0]   O_EVT_TIME,
  output logic      [NS*CNT_W-1:0] O_CNT_START,
  output logic      [NS*CNT_W-1:0] O_CNT_TRIP,
  output logic      [NS*CNT_W-1:0] O_CNT_BLOCK,
  output logic      [REC_W-1:0]    O_REC_DATA,
  output logic      [REC_AW-1:0]   O_REC_COUNT
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  // Active delay selection shared by all stages
  function automatic logic [DLY_W-1:0] pick_delay(
    input logic             broad,
    input logic             sep,
    input logic             inv,
    input logic             res,
    input logic             cap,
    input logic [DLY_W-1:0] common,
    input logic [DLY_W-1:0] comp,
    input logic [DLY_W-1:0] unearth,
    input logic [DLY_W-1:0] invd
  );
    logic [DLY_W-1:0] d;
    d = common;
    if (broad && sep) begin
      if (res && cap) begin
        d = (comp < unearth) ? comp : unearth;
      end else if (res) begin
        d = comp;
      end else if (cap) begin
        d = unearth;
      end
    end else if (inv && !broad) begin
      d = invd;
    end
    return d;
  endfunction : pick_delay

  // Settings held in registers with their default values
  logic [NS-1:0]      inrush_en;
  logic [RATIO_W-1:0] ratio_lim [NS];
  logic [NS-1:0]      broad;
  logic [NS-1:0]      separate;
  logic [NS-1:0]      inverse;
  logic [DLY_W-1:0]   dly_common [NS];
  logic [DLY_W-1:0]   dly_comp [NS];
  logic [DLY_W-1:0]   dly_unearth [NS];
  logic [DLY_W-1:0]   dly_rel [NS];
  logic [NUM_ST-1:0]  evt_on;
  logic [NUM_ST-1:0]  evt_off;

  logic [TW-1:0]      tick_cnt;
  logic               tick;
  logic [MEAS_W-1:0]  hist [HIST_DEPTH];
  logic [NS-1:0]      pick_q;
  logic [NS-1:0]      blk_q;
  logic [NS-1:0]      res_q;
  logic [NS-1:0]      cap_q;
  stage_state_t       state [NS];
  stage_state_t       next_state [NS];
  logic [DLY_W-1:0]   elapsed [NS];
  logic [DLY_W-1:0]   rel_cnt [NS];
  logic [DLY_W-1:0]   act_dly [NS];
  logic [DLY_W-1:0]   remain [NS];
  logic [NUM_ST-1:0]  st [NS];
  logic [NUM_ST-1:0]  next_st [NS];
  logic [NUM_ST-1:0]  st_d [NS];
  logic [NUM_EVT-1:0] pend [NS];
  logic [NUM_EVT-1:0] set_ev [NS];
  logic [TIME_W-1:0]  stamp [NS][NUM_EVT];
  logic               found;
  logic [STAGE_W-1:0] sel_s;
  logic [EVT_W-1:0]   sel_e;
  logic [NS-1:0]      rec_wr;
  logic [REC_W-1:0]   rec_wdata [NS];
  logic [REC_W-1:0]   rec_rdata [NS];
  logic [REC_AW-1:0]  rec_count [NS];
  logic [STAGE_W-1:0] rec_stage_q;

  // Configuration load; inrush off, 0.040 s operate delays and zero release delay after reset
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      inrush_en <= '0;
      broad     <= '0;
      separate  <= '0;
      inverse   <= '0;
      evt_on    <= '1;
      evt_off   <= '1;
      for (int s = 0; s < NS; s++) begin
        ratio_lim[s]   <= RATIO_DEFAULT;
        dly_common[s]  <= DLY_DEFAULT;
        dly_comp[s]    <= DLY_DEFAULT;
        dly_unearth[s] <= DLY_DEFAULT;
        dly_rel[s]     <= '0;
      end
    end else if (I_CE && I_CFG_LOAD) begin
      inrush_en <= I_CFG_INRUSH_EN;
      broad     <= I_CFG_BROAD;
      separate  <= I_CFG_SEPARATE;
      inverse   <= I_CFG_INVERSE;
      evt_on    <= I_CFG_EVT_ON;
      evt_off   <= I_CFG_EVT_OFF;
      for (int s = 0; s < NS; s++) begin
        ratio_lim[s]   <= I_CFG_RATIO_LIMIT[s*RATIO_W +: RATIO_W];
        dly_common[s]  <= I_CFG_DLY_COMMON[s*DLY_W +: DLY_W];
        dly_comp[s]    <= I_CFG_DLY_COMP[s*DLY_W +: DLY_W];
        dly_unearth[s] <= I_CFG_DLY_UNEARTH[s*DLY_W +: DLY_W];
        dly_rel[s]     <= I_CFG_DLY_RELEASE[s*DLY_W +: DLY_W];
      end
    end
  end

  // Delay step tick every 5 ms
  assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tick_cnt <= '0;
    end else if (I_CE) begin
      tick_cnt <= tick ? '0 : TW'(tick_cnt + TW'(1));
    end
  end

  // Residual current history for pre-fault values
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist[i] <= '0;
      end
    end else if (I_CE && tick) begin
      hist[0] <= I_RES_CURRENT;
      for (int i = 1; i < HIST_DEPTH; i++) begin
        hist[i] <= hist[i-1];
      end
    end
  end

  // Snapshot of pick-up and blocking at the start of the cycle
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pick_q <= '0;
      blk_q  <= '0;
      res_q  <= '0;
      cap_q  <= '0;
    end else if (I_CE) begin
      pick_q <= I_PICKUP;
      res_q  <= I_RES_PICKUP;
      cap_q  <= I_CAP_PICKUP;
      for (int s = 0; s < NS; s++) begin
        blk_q[s] <= I_BLOCK[s]
                    | (inrush_en[s] && (I_HARM_RATIO > ratio_lim[s]));
      end
    end
  end

  // Active delay and remaining time per stage
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      // fixed or inverse, no inverse in broad range
      act_dly[s] = pick_delay(broad[s], separate[s], inverse[s],
                              res_q[s], cap_q[s], dly_common[s],
                              dly_comp[s], dly_unearth[s],
                              I_INV_DELAY[s*DLY_W +: DLY_W]);
      remain[s]  = (act_dly[s] > elapsed[s])
                   ? DLY_W'(act_dly[s] - elapsed[s]) : '0;
    end
  end

  // Stage sequencing and next status
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      next_state[s] = state[s];
      case (state[s])
        S_IDLE: begin
          if (pick_q[s] && blk_q[s]) begin
            next_state[s] = S_BLOCKED;
          end else if (pick_q[s]) begin
            next_state[s] = S_START;
          end
        end
        S_START: begin
          if (blk_q[s] || !pick_q[s]) begin
            next_state[s] = S_IDLE;
          end else if (elapsed[s] >= act_dly[s]) begin
            next_state[s] = S_TRIP;
          end
        end
        S_TRIP: begin
          if (blk_q[s] || !pick_q[s]) begin
            next_state[s] = S_IDLE;
          end
        end
        S_BLOCKED: begin
          if (!pick_q[s]) begin
            next_state[s] = S_IDLE;
          end
        end
        default: next_state[s] = S_IDLE;
      endcase
      next_st[s]               = '0;
      next_st[s][ST_START]     = (next_state[s] == S_START);
      next_st[s][ST_TRIP]      = (next_state[s] == S_TRIP);
      next_st[s][ST_BLOCK]     = (next_state[s] == S_BLOCKED);
      next_st[s][ST_RES_START] = (next_state[s] == S_START) && res_q[s];
      next_st[s][ST_CAP_START] = (next_state[s] == S_START) && cap_q[s];
      next_st[s][ST_RES_TRIP]  = (next_state[s] == S_TRIP) && res_q[s];
      next_st[s][ST_CAP_TRIP]  = (next_state[s] == S_TRIP) && cap_q[s];
    end
  end

  // State, status and elapsed time registers
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      for (int s = 0; s < NS; s++) begin
        state[s]   <= S_IDLE;
        st[s]      <= '0;
        st_d[s]    <= '0;
        elapsed[s] <= '0;
        rel_cnt[s] <= '0;
      end
    end else if (I_CE) begin
      for (int s = 0; s < NS; s++) begin
        state[s] <= next_state[s];
        st[s]    <= next_st[s];
        st_d[s]  <= st[s];
        if (state[s] == S_START) begin
          rel_cnt[s] <= '0;
          if (tick && elapsed[s] != '1) begin
            elapsed[s] <= DLY_W'(elapsed[s] + DLY_W'(1));
          end
        end else if (state[s] == S_IDLE && elapsed[s] != '0) begin
          // release timing after drop or block
          if (rel_cnt[s] >= dly_rel[s]) begin
            elapsed[s] <= '0;
            rel_cnt[s] <= '0;
          end else if (tick) begin
            rel_cnt[s] <= DLY_W'(rel_cnt[s] + DLY_W'(1));
          end
        end else if (state[s] == S_BLOCKED) begin
          elapsed[s] <= '0;
          rel_cnt[s] <= '0;
        end
      end
    end
  end

  // Edge detection into enabled event requests
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      for (int k = 0; k < NUM_ST; k++) begin
        set_ev[s][2*k]   = st[s][k] && !st_d[s][k] && evt_on[k];
        set_ev[s][2*k+1] = !st[s][k] && st_d[s][k] && evt_off[k];
      end
    end
  end

  // Lowest pending event, stage by stage
  always_comb begin
    found = 1'b0;
    sel_s = '0;
    sel_e = '0;
    for (int s = 0; s < NS; s++) begin
      for (int e = 0; e < NUM_EVT; e++) begin
        if (pend[s][e] && !found) begin
          found = 1'b1;
          sel_s = STAGE_W'(s);
          sel_e = EVT_W'(e);
        end
      end
    end
  end

  // Pending events and their stamps; a new edge beats the clear
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      for (int s = 0; s < NS; s++) begin
        pend[s] <= '0;
        for (int e = 0; e < NUM_EVT; e++) begin
          stamp[s][e] <= '0;
        end
      end
    end else if (I_CE) begin
      for (int s = 0; s < NS; s++) begin
        for (int e = 0; e < NUM_EVT; e++) begin
          if (set_ev[s][e]) begin
            pend[s][e]  <= 1'b1;
            stamp[s][e] <= I_TIME_MS;
          end else if (found && sel_s == STAGE_W'(s)
                       && sel_e == EVT_W'(e)) begin
            pend[s][e] <= 1'b0;
          end
        end
      end
    end
  end

  // Event output, one per clock, tagged with its stage
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_EVT_VALID <= 1'b0;
      O_EVT_STAGE <= '0;
      O_EVT_CODE  <= '0;
      O_EVT_TIME  <= '0;
    end else if (I_CE) begin
      O_EVT_VALID <= found;
      if (found) begin
        O_EVT_STAGE <= sel_s;
        O_EVT_CODE  <= sel_e;
        O_EVT_TIME  <= stamp[sel_s][sel_e];
      end
    end
  end

  // Cumulative counters and remaining time
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_CNT_START <= '0;
      O_CNT_TRIP  <= '0;
      O_CNT_BLOCK <= '0;
      O_REMAIN    <= '0;
    end else if (I_CE) begin
      for (int s = 0; s < NS; s++) begin
        O_REMAIN[s*DLY_W +: DLY_W] <= remain[s];
        if (st[s][ST_START] && !st_d[s][ST_START]) begin
          O_CNT_START[s*CNT_W +: CNT_W] <=
            CNT_W'(O_CNT_START[s*CNT_W +: CNT_W] + CNT_W'(1));
        end
        if (st[s][ST_TRIP] && !st_d[s][ST_TRIP]) begin
          O_CNT_TRIP[s*CNT_W +: CNT_W] <=
            CNT_W'(O_CNT_TRIP[s*CNT_W +: CNT_W] + CNT_W'(1));
        end
        if (st[s][ST_BLOCK] && !st_d[s][ST_BLOCK]) begin
          O_CNT_BLOCK[s*CNT_W +: CNT_W] <=
            CNT_W'(O_CNT_BLOCK[s*CNT_W +: CNT_W] + CNT_W'(1));
        end
      end
    end
  end

  // Status outputs straight from the status flops
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      O_START[s]     = st[s][ST_START];
      O_TRIP[s]      = st[s][ST_TRIP];
      O_BLOCKED[s]   = st[s][ST_BLOCK];
      O_RES_START[s] = st[s][ST_RES_START];
      O_CAP_START[s] = st[s][ST_CAP_START];
      O_RES_TRIP[s]  = st[s][ST_RES_TRIP];
      O_CAP_TRIP[s]  = st[s][ST_CAP_TRIP];
    end
  end

  // Fault record assembly on rising start, trip or blocked
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      logic [KIND_W-1:0] kind;
      kind = REC_START;
      if (next_st[s][ST_TRIP]) begin
        kind = REC_TRIP;
      end else if (next_st[s][ST_BLOCK]) begin
        kind = REC_BLOCK;
      end
      rec_wr[s] = |(next_st[s][ST_BLOCK:ST_START]
                    & ~st[s][ST_BLOCK:ST_START]);
      rec_wdata[s] = {kind, I_TIME_MS, hist[PRE_SHORT_IDX],
                      hist[PRE_LONG_IDX], I_RES_CURRENT, I_CAP_PART,
                      I_RES_PART, I_RESID_V_PCT, I_RESID_V_VOLT, I_ANGLE,
                      remain[s], I_SET_GROUP, I_NET_GND};
    end
  end

  for (genvar g = 0; g < NS; g++) begin : g_rec
    ef_rec_mem #(
      .WIDTH (REC_W),
      .DEPTH (REC_DEPTH),
      .AW    (REC_AW)
    ) u_rec (
      .i_clk   (I_CLK),
      .i_rst   (I_SYS_RST),
      .i_ce    (I_CE),
      .i_wr    (rec_wr[g]),
      .i_wdata (rec_wdata[g]),
      .i_age   (I_REC_AGE),
      .o_rdata (rec_rdata[g]),
      .o_count (rec_count[g])
    );
  end

  // Record read port, two clocks from request
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rec_stage_q <= '0;
      O_REC_DATA  <= '0;
      O_REC_COUNT <= '0;
    end else if (I_CE) begin
      rec_stage_q <= I_REC_STAGE;
      O_REC_DATA  <= rec_rdata[rec_stage_q];
      O_REC_COUNT <= rec_count[rec_stage_q];
    end
  end

endmodule : ef_stage_block

`default_nettype wire

// >>> common/ef_stage_pkg.sv
// Constants and types shared by the earth fault stage block
package ef_stage_pkg;

  // Stage count and clocking
  localparam int NUM_STAGES  = 4;
  localparam int STAGE_W     = 2;
  localparam int CLK_HZ      = 50_000_000;
  localparam int TICK_US     = 5000;       // Delay step of 0.005 s
  localparam int TICK_MS     = TICK_US / 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

  // Delay settings counted in 5 ms steps, up to 1800 s
  localparam int DLY_W          = 19;
  localparam int DLY_DEFAULT_MS = 40;
  localparam logic [DLY_W-1:0] DLY_DEFAULT = DLY_W'(DLY_DEFAULT_MS / TICK_MS);

  // Inrush ratio in 0.01 percent steps of the fundamental
  localparam int RATIO_W = 13;
  localparam logic [RATIO_W-1:0] RATIO_DEFAULT = 13'h0001;

  // Measurement and record field widths
  localparam int MEAS_W = 16;
  localparam int TIME_W = 32;
  localparam int GRP_W  = 3;
  localparam int GND_W  = 2;
  localparam int CNT_W  = 16;

  // Status bits, each one an event source
  localparam int NUM_ST       = 7;
  localparam int ST_START     = 0;
  localparam int ST_TRIP      = 1;
  localparam int ST_BLOCK     = 2;
  localparam int ST_RES_START = 3;
  localparam int ST_CAP_START = 4;
  localparam int ST_RES_TRIP  = 5;
  localparam int ST_CAP_TRIP  = 6;

  // Event code is twice the status bit, plus one for the off edge
  localparam int NUM_EVT = 2 * NUM_ST;
  localparam int EVT_W   = 4;

  // Fault record kinds
  localparam int KIND_W = 2;
  localparam logic [KIND_W-1:0] REC_START = 2'h0;
  localparam logic [KIND_W-1:0] REC_TRIP  = 2'h1;
  localparam logic [KIND_W-1:0] REC_BLOCK = 2'h2;
  localparam int REC_DEPTH = 12;
  localparam int REC_AW    = 4;
  localparam int REC_W     = KIND_W + TIME_W + 8 * MEAS_W + DLY_W
                             + GRP_W + GND_W;

  // Residual current history for pre-fault values
  localparam int PRE_SHORT_MS  = 20;
  localparam int PRE_LONG_MS   = 200;
  localparam int HIST_DEPTH    = PRE_LONG_MS / TICK_MS;
  localparam int PRE_SHORT_IDX = PRE_SHORT_MS / TICK_MS - 1;
  localparam int PRE_LONG_IDX  = HIST_DEPTH - 1;

  // Stage sequencing states
  typedef enum logic [1:0] {
    S_IDLE,
    S_START,
    S_TRIP,
    S_BLOCKED
  } stage_state_t;

endpackage : ef_stage_pkg

// >>> hdl/ef_rec_mem.sv
// Circular fault record store keeping the newest entries of one stage
`timescale 1ns/1ns
`default_nettype none

module ef_rec_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 12,
  parameter int AW    = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_wr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic [AW-1:0]    i_age,
  output logic      [WIDTH-1:0] o_rdata,
  output logic      [AW-1:0]    o_count
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    raddr;

  // Age zero is the newest record, wrapping around the ring
  always_comb begin
    if (wptr > i_age) begin
      raddr = AW'(wptr - i_age - AW'(1));
    end else begin
      raddr = AW'(DEPTH) + wptr - i_age - AW'(1);
    end
  end

  // Write overwrites the oldest slot once the ring is full
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wptr    <= '0;
      o_count <= '0;
    end else if (i_ce && i_wr) begin
      wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : AW'(wptr + AW'(1));
      if (o_count != AW'(DEPTH)) begin
        o_count <= AW'(o_count + AW'(1));
      end
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge i_clk) begin
    if (i_ce && i_wr) begin
      mem[wptr] <= i_wdata;
    end
  end

  // Registered read data
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= mem[raddr];
    end
  end

endmodule : ef_rec_mem

`default_nettype wire

// >>> tb/ef_stage_props.sv
// Checker for stage sequencing, events, counters and records
`timescale 1ns/1ns
`default_nettype none
module ef_stage_props
  import ef_stage_pkg::*;
#(
  parameter int NS = NUM_STAGES
) (
  input wire logic                I_CLK,
  input wire logic                I_SYS_RST,
  input wire logic [NS-1:0]       I_PICKUP,
  input wire logic [NS-1:0]       I_BLOCK,
  input wire logic [NS-1:0]       O_START,
  input wire logic [NS-1:0]       O_TRIP,
  input wire logic [NS-1:0]       O_BLOCKED,
  input wire logic                O_EVT_VALID,
  input wire logic [STAGE_W-1:0]  O_EVT_STAGE,
  input wire logic [EVT_W-1:0]    O_EVT_CODE,
  input wire logic [NS*CNT_W-1:0] O_CNT_START,
  input wire logic [REC_AW-1:0]   O_REC_COUNT
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // Stage 0 shows no status at all
  logic idle;
  assign idle = !O_START[0] && !O_TRIP[0] && !O_BLOCKED[0];
  // Pick-up rising on an idle stage, and start rising
  sequence s_rise;
    idle && $rose(I_PICKUP[0]);
  endsequence
  sequence s_start_on;
    $rose(O_START[0]);
  endsequence
  free_start_a: assert property (s_rise ##0 !I_BLOCK[0] |-> ##2 O_START[0])
    else $error("start missing after free pick-up");
  blk_pick_a: assert property (s_rise ##0 I_BLOCK[0]
    |-> ##2 (O_BLOCKED[0] && !O_START[0])) else $error("blocked missing");
  blk_hold_a: assert property (O_BLOCKED[0] && $past(I_PICKUP[0])
    |=> O_BLOCKED[0] && !O_START[0]) else $error("blocked left early");
  late_blk_a: assert property (O_START[0] && $past(I_BLOCK[0])
    |=> !O_START[0] && !O_TRIP[0]) else $error("start kept under block");
  trip_drop_a: assert property (O_TRIP[0] && !$past(I_PICKUP[0])
    |=> !O_TRIP[0]) else $error("trip kept after drop");
  start_evt_a: assert property (s_start_on |-> ##[1:16]
    (O_EVT_VALID && O_EVT_CODE == 4'h0 && O_EVT_STAGE == 2'h0))
    else $error("start event missing");
  start_cnt_a: assert property (s_start_on |-> ##1
    O_CNT_START[15:0] == $past(O_CNT_START[15:0], 2) + 16'h1)
    else $error("start counter wrong");
  rec_bound_a: assert property (O_REC_COUNT <= 4'hc)
    else $error("record count above depth");
endmodule : ef_stage_props
bind ef_stage_block ef_stage_props #(.NS(NS)) i_ef_stage_props (.*);
`default_nettype wire

// >>> tb/ef_far_model.sv
// Far side: blocking matrix and event buffer sink
`timescale 1ns/1ns
`default_nettype none
module ef_far_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_blk_req,
  input  wire logic       i_evt_valid,
  output logic      [3:0] o_blk,
  output logic      [7:0] o_evt_cnt
);
  // block registered well before any delay ends
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_blk <= 4'h0;
    else o_blk <= i_blk_req;
  end
  // Event buffer counts every pulse
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_evt_cnt <= 8'h0;
    else if (i_evt_valid) o_evt_cnt <= o_evt_cnt + 8'h1;
  end
endmodule : ef_far_model
`default_nettype wire

// >>> tb/ef_stage_block_tb.sv
// Self-checking bench for the earth fault stage block
`timescale 1ns/1ns
`default_nettype none
module ef_stage_block_tb;
  import ef_stage_pkg::*;
  logic I_CLK, I_SYS_RST, I_CE, I_CFG_LOAD;
  logic [3:0] I_PICKUP, I_RES_PICKUP, I_CAP_PICKUP, blk_req;
  logic [3:0] I_CFG_INRUSH_EN, I_CFG_BROAD, I_CFG_SEPARATE, I_CFG_INVERSE;
  logic [4*DLY_W-1:0] I_INV_DELAY, I_CFG_DLY_COMMON, I_CFG_DLY_COMP;
  logic [4*DLY_W-1:0] I_CFG_DLY_UNEARTH, I_CFG_DLY_RELEASE;
  logic [4*RATIO_W-1:0] I_CFG_RATIO_LIMIT;
  logic [RATIO_W-1:0] I_HARM_RATIO;
  logic [MEAS_W-1:0] I_RES_CURRENT, I_RES_PART, I_CAP_PART, I_RESID_V_PCT;
  logic [MEAS_W-1:0] I_RESID_V_VOLT, I_ANGLE;
  logic [GRP_W-1:0] I_SET_GROUP;
  logic [GND_W-1:0] I_NET_GND;
  logic [TIME_W-1:0] I_TIME_MS, ts, tdrop;
  logic [NUM_ST-1:0] I_CFG_EVT_ON, I_CFG_EVT_OFF;
  logic [STAGE_W-1:0] I_REC_STAGE;
  logic [REC_AW-1:0] I_REC_AGE;
  logic [7:0] e0;
  wire [3:0] I_BLOCK, O_START, O_TRIP, O_BLOCKED, O_RES_START, O_CAP_START;
  wire [3:0] O_RES_TRIP, O_CAP_TRIP;
  wire [4*DLY_W-1:0] O_REMAIN;
  wire O_EVT_VALID;
  wire [STAGE_W-1:0] O_EVT_STAGE;
  wire [EVT_W-1:0] O_EVT_CODE;
  wire [TIME_W-1:0] O_EVT_TIME;
  wire [4*CNT_W-1:0] O_CNT_START, O_CNT_TRIP, O_CNT_BLOCK;
  wire [REC_W-1:0] O_REC_DATA;
  wire [REC_AW-1:0] O_REC_COUNT;
  wire [7:0] evt_cnt;
  int num_errors;
  int compares;
  ef_stage_block #(.TICK_CYCLES(4)) i_ef_stage_block (.*);
  ef_far_model i_ef_far_model (.i_clk(I_CLK), .i_rst(I_SYS_RST),
    .i_blk_req(blk_req), .i_evt_valid(O_EVT_VALID), .o_blk(I_BLOCK),
    .o_evt_cnt(evt_cnt));
  task tick(input int n);
    repeat (n) @(posedge I_CLK);
    #2;
  endtask : tick
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got);
      num_errors++;
    end
  endtask : chk
  function automatic logic st(input int k, input int s);
    return k == 0 ? O_START[s] : k == 1 ? O_TRIP[s] : O_BLOCKED[s];
  endfunction : st
  task wait_st(input int k, input int s);
    int n;
    for (n = 0; n < 200 && st(k, s) !== 1'b1; n++) tick(1);
    if (n == 200) begin
      $display("[FAIL] status %0d expected 1 seen 0", k);
      num_errors++;
      give_verdict();
    end
  endtask : wait_st
  task give_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // Free pick-up runs to trip, then drops
  task s_start_trip();
    e0 = evt_cnt;
    I_PICKUP[0] = 1'b1;
    wait_st(0, 0);
    ts = I_TIME_MS;
    wait_st(1, 0);
    chk("delay", 1, (I_TIME_MS - ts) inside {[28:37]});
    chk("start", 0, O_START[0]);
    tick(2);
    chk("cnt trip", 1, O_CNT_TRIP[15:0]);
    chk("rec kind", REC_TRIP, O_REC_DATA[REC_W-1 -: KIND_W]);
    chk("rec count", 2, O_REC_COUNT);
    tdrop = I_TIME_MS;
    I_PICKUP[0] = 1'b0;
    tick(8);
    chk("trip", 0, O_TRIP[0]);
    chk("events", 4, evt_cnt - e0);
    chk("code", 3, O_EVT_CODE);
    chk("stamp", 1, O_EVT_TIME > tdrop && O_EVT_TIME <= I_TIME_MS);
  endtask : s_start_trip
  // Pick-up under block stays blocked
  task s_blocked();
    blk_req[0] = 1'b1;
    tick(3);
    I_PICKUP[0] = 1'b1;
    wait_st(2, 0);
    tick(40);
    chk("no start", 0, O_START[0] | O_TRIP[0]);
    chk("cnt block", 1, O_CNT_BLOCK[15:0]);
    chk("rec kind", REC_BLOCK, O_REC_DATA[REC_W-1 -: KIND_W]);
    chk("rec group", 5, O_REC_DATA[4:0]);
    I_PICKUP[0] = 1'b0;
    blk_req[0] = 1'b0;
    tick(6);
    chk("blocked", 0, O_BLOCKED[0]);
  endtask : s_blocked
  // Block arriving after start cancels the trip
  task s_late_block();
    I_PICKUP[0] = 1'b1;
    wait_st(0, 0);
    tick(4);
    blk_req[0] = 1'b1;
    tick(4);
    chk("start", 0, O_START[0]);
    tick(40);
    chk("trip", 0, O_TRIP[0]);
    chk("cnt start", 2, O_CNT_START[15:0]);
    I_PICKUP[0] = 1'b0;
    blk_req[0] = 1'b0;
    tick(6);
  endtask : s_late_block
  // Inrush option on stage 1 blocks above the limit only
  task s_inrush();
    I_PICKUP[1] = 1'b1;
    wait_st(0, 1);
    I_PICKUP[1] = 1'b0;
    tick(6);
    I_CFG_LOAD = 1'b1;
    tick(1);
    I_CFG_LOAD = 1'b0;
    I_PICKUP[1] = 1'b1;
    wait_st(2, 1);
    chk("inrush start", 0, O_START[1]);
    I_PICKUP[1] = 1'b0;
    I_HARM_RATIO = 13'h0032;
    tick(6);
    I_PICKUP[1] = 1'b1;
    wait_st(0, 1);
    I_PICKUP[1] = 1'b0;
    tick(6);
  endtask : s_inrush
  // Broad range stage 2: separate resistive delay, inverse ignored
  task s_broad();
    I_PICKUP[2] = 1'b1;
    I_RES_PICKUP[2] = 1'b1;
    wait_st(0, 2);
    ts = I_TIME_MS;
    chk("res start", 1, O_RES_START[2]);
    wait_st(1, 2);
    chk("sep delay", 1, (I_TIME_MS - ts) inside {[12:21]});
    chk("res trip", 1, O_RES_TRIP[2] & !O_CAP_TRIP[2]);
    chk("remain", 0, O_REMAIN[2*DLY_W +: DLY_W]);
    {I_PICKUP[2], I_RES_PICKUP[2]} = 2'h0;
    tick(6);
  endtask : s_broad
  initial begin
    I_CLK = 1'b0;
    forever #10 I_CLK = ~I_CLK;
  end
  // Time base and a moving measurement
  always @(posedge I_CLK)
    I_TIME_MS <= #2 I_SYS_RST ? 32'h0 : I_TIME_MS + 32'h1;
  assign I_RES_CURRENT = I_TIME_MS[15:0];
  initial begin
    {I_CE, I_SYS_RST, I_CFG_LOAD} = 3'h6;
    {I_PICKUP, I_RES_PICKUP, I_CAP_PICKUP, blk_req} = 16'h0;
    {I_CFG_BROAD, I_CFG_SEPARATE, I_CFG_INVERSE} = 12'h444;
    I_CFG_INRUSH_EN = 4'h2;
    I_INV_DELAY = {4{19'h00010}};
    I_CFG_DLY_COMMON = {4{19'h00008}};
    I_CFG_DLY_COMP = {4{19'h00004}};
    I_CFG_DLY_UNEARTH = {4{19'h00008}};
    I_CFG_DLY_RELEASE = '0;
    I_CFG_RATIO_LIMIT = {4{13'h0064}};
    I_HARM_RATIO = 13'h00c8;
    {I_RES_PART, I_CAP_PART} = 32'h00110022;
    {I_RESID_V_PCT, I_RESID_V_VOLT} = 32'h00330044;
    I_ANGLE = 16'h005a;
    {I_SET_GROUP, I_NET_GND} = 5'h05;
    {I_CFG_EVT_ON, I_CFG_EVT_OFF} = 14'h3fff;
    {I_REC_STAGE, I_REC_AGE} = 6'h0;
    tick(8);
    I_SYS_RST = 1'b0;
    chk("reset", 0, O_START);
    s_start_trip();
    s_blocked();
    s_late_block();
    s_inrush();
    s_broad();
    give_verdict();
  end
endmodule : ef_stage_block_tb
`default_nettype wire
